// ### hdl/uaf_top.sv
/*
 * uaf_top: serial port transmit and receive datapath with sixteen-entry fifos,
 * receive time-out, and automatic request-to-send / clear-to-send flow control.
 * assumes: plain register port, read data one cycle after the read strobe;
 * RX and CTS_N are asynchronous pins; one clock, asynchronous active-low reset.
 */
// The placing of the registers and the plain strobed port are this design's own decisions.
// Contract
// - bit time is 16, 8 or 4 sampling ticks; shifter sends one bit each.
// - frame is start, data bits, optional parity, then one or two stop bits.
// - data leaves least significant bit first.
// - in fifo mode each holding write pushes the sixteen-byte transmit fifo unless it is already full.
// - non-fifo mode: holding-empty flag sets when byte moves to shifter.
// - fifo mode: holding-empty flag set whenever transmit fifo is empty.
// - interrupt enable bit 1 lets holding-empty raise source bit 1.
// - transmitter-empty flag only when shifter and fifo both empty.
// - start edge resampled after half a bit; high line means false start.
// - data and stop bits sampled mid-bit by the same counting.
// - receive fifo is sixteen entries of character plus three error tags.
// - reading receive holding pops fifo; status tags follow new head at once.
// - enable bit 0 raises receive interrupt per character or at trigger level.
// - data idle four characters plus twelve bits raises receive time-out.
// - automatic request-to-send only with enhanced feature bit 6.
// - enable bit 6 flags request-to-send low-to-high in source bit 5.
// - request-to-send off/on thresholds follow the hysteresis table per trigger.
// - receiver keeps accepting characters until the fifo is full.
// - automatic clear-to-send only with enhanced feature bit 7.
// - enable bit 7 flags clear-to-send going high in source bit 5.
// - with clear-to-send high, transmitter pauses after the current stop bit.
// - fractional divisor bits 5:4 pick 16X, 8X or 4X sampling.
`timescale 1ns/10ps
module uaf_top (
	input  wire logic       SYS_CLK,
	input  wire logic       RSTN,
	input  wire logic [3:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	output logic      [7:0] RDATA,
	input  wire logic       RX,
	output logic            TX,
	input  wire logic       CTS_N,
	output logic            RTS_N,
	output logic            INT
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] mask_wl(input logic [7:0] d, input logic [1:0] wl);
		return d & (8'hFF >> (2'h3 - wl));
	endfunction

	function automatic logic par_of(input logic [7:0] d, input logic [7:0] lc);
		logic p;
		p = ^mask_wl(d, lc[1:0]);
		return lc[uaf_pkg::LC_EVEN] ? p : ~p;
	endfunction

	function automatic logic is_full(input logic [4:0] cnt, input logic fifo_on);
		return fifo_on ? (cnt == uaf_pkg::FIFO_DEPTH) : (cnt != 5'h00);
	endfunction

	// ----------------------------------------------------------------
	// registers and state
	// ----------------------------------------------------------------
	logic [7:0] ien_r;
	logic [7:0] fctl_r;
	logic [7:0] lctl_r;
	logic [7:0] mctl_r;
	logic [7:0] efeat_r;
	logic [7:0] fdiv_r;
	logic [7:0] bdiv_r;
	logic [7:0] rdata_r;
	logic [2:0] rx_s_r;
	logic [2:0] cts_s_r;
	logic       rx_r;
	logic       rx_prev_r;
	logic       cts_n_r;
	logic       cts_d_r;
	logic [7:0] div_cnt_r;
	logic       tick;
	logic [4:0] os_n;
	logic [2:0] last_bit;
	uaf_pkg::tx_state_t tx_st_r;
	uaf_pkg::rx_state_t rx_st_r;
	logic [4:0] tx_cnt_r;
	logic [2:0] tx_bit_r;
	logic [7:0] tx_sh_r;
	logic       tx_par_r;
	logic       tx_stp_r;
	logic       tx_o_r;
	logic       tx_end;
	logic       tx_go;
	logic [4:0] rx_cnt_r;
	logic [2:0] rx_bit_r;
	logic [7:0] rx_sh_r;
	logic       rx_pe_r;
	logic       rx_pb_r;
	logic       rx_end;
	logic       rx_mid;
	logic [7:0] rx_data;
	logic       rx_push;
	logic       rx_brk;
	logic       oe_r;
	logic [4:0] bt_cnt_r;
	logic [7:0] tmo_cnt_r;
	logic [7:0] tmo_lim;
	logic       tmo_r;
	logic       thre_d_r;
	logic       thri_r;
	logic       flow_r;
	logic       rts_off_r;
	logic       rts_n_r;
	logic       rts_d_r;
	logic       int_r;
	logic [7:0] txf_dout;
	logic [4:0] txf_cnt;
	logic [10:0] rxf_dout;
	logic [4:0] rxf_cnt;
	logic       wr_data;
	logic       rd_data;
	logic       rd_isrc;
	logic       thre;
	logic       temt;
	logic       rxf_empty;
	logic       rxd_cond;
	logic [5:0] isrc;
	logic [7:0] lstat;
	logic [1:0] tsel;

	// ----------------------------------------------------------------
	// register port decode
	// ----------------------------------------------------------------
	assign wr_data   = WR && (ADDR == uaf_pkg::A_DATA);
	assign rd_data   = RD && (ADDR == uaf_pkg::A_DATA) && !rxf_empty;
	assign rd_isrc   = RD && (ADDR == uaf_pkg::A_ISRC);
	assign rxf_empty = (rxf_cnt == 5'h00);
	assign tsel      = fctl_r[uaf_pkg::FC_TRIG +: 2];

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			ien_r   <= uaf_pkg::ZERO_RST;
			fctl_r  <= uaf_pkg::ZERO_RST;
			lctl_r  <= uaf_pkg::LCTL_RST;
			mctl_r  <= uaf_pkg::ZERO_RST;
			efeat_r <= uaf_pkg::ZERO_RST;
			fdiv_r  <= uaf_pkg::ZERO_RST;
			bdiv_r  <= uaf_pkg::ZERO_RST;
		end else if (WR) begin
			unique case (ADDR)
				// upper enables stay locked until enhanced mode is on
				uaf_pkg::A_IEN: ien_r <= efeat_r[uaf_pkg::EF_ENH] ? WDATA
					: {ien_r[7:4], WDATA[3:0]};
				uaf_pkg::A_ISRC:  fctl_r  <= {WDATA[7:6], 5'h00, WDATA[0]};
				uaf_pkg::A_LCTL:  lctl_r  <= WDATA;
				uaf_pkg::A_MCTL:  mctl_r  <= WDATA;
				uaf_pkg::A_EFEAT: efeat_r <= WDATA;
				uaf_pkg::A_FDIV:  fdiv_r  <= WDATA;
				uaf_pkg::A_BDIV:  bdiv_r  <= WDATA;
				default: ;
			endcase
		end
	end

	always_comb begin
		lstat = {1'b0, temt, thre, 3'h0, oe_r, !rxf_empty};
		if (!rxf_empty) begin
			lstat[4:2] = rxf_dout[10:8];
		end
	end

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			rdata_r <= 8'h00;
		end else if (RD) begin
			unique case (ADDR)
				uaf_pkg::A_DATA:  rdata_r <= rxf_empty ? 8'h00 : rxf_dout[7:0];
				uaf_pkg::A_IEN:   rdata_r <= ien_r;
				uaf_pkg::A_ISRC:  rdata_r <= {{2{fctl_r[uaf_pkg::FC_EN]}}, isrc};
				uaf_pkg::A_LCTL:  rdata_r <= lctl_r;
				uaf_pkg::A_MCTL:  rdata_r <= mctl_r;
				uaf_pkg::A_LSTAT: rdata_r <= lstat;
				uaf_pkg::A_EFEAT: rdata_r <= efeat_r;
				uaf_pkg::A_FDIV:  rdata_r <= fdiv_r;
				uaf_pkg::A_BDIV:  rdata_r <= bdiv_r;
				default:          rdata_r <= 8'h00;
			endcase
		end else begin
			rdata_r <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// pin synchronisers and sampling tick
	// ----------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			rx_s_r  <= 3'h7;
			cts_s_r <= 3'h7;
			rx_r    <= 1'b1;
			cts_n_r <= 1'b1;
		end else begin
			rx_s_r  <= {rx_s_r[1:0], RX};
			cts_s_r <= {cts_s_r[1:0], CTS_N};
			if (rx_s_r[1] == rx_s_r[2]) begin
				rx_r <= rx_s_r[2];
			end
			if (cts_s_r[1] == cts_s_r[2]) begin
				cts_n_r <= cts_s_r[2];
			end
		end
	end

	assign tick     = (div_cnt_r == bdiv_r);
	assign os_n     = uaf_pkg::OS_LEN[fdiv_r[uaf_pkg::FD_OS +: 2]];
	assign last_bit = {1'b0, lctl_r[1:0]} + 3'h4;

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			div_cnt_r <= 8'h00;
		end else begin
			div_cnt_r <= tick ? 8'h00 : div_cnt_r + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// transmitter
	// ----------------------------------------------------------------
	uaf_fifo #(.W(8)) u_txf (
		.clk   (SYS_CLK),
		.rstn  (RSTN),
		.clr   (WR && ADDR == uaf_pkg::A_ISRC && WDATA[uaf_pkg::FC_TXCLR]),
		.push  (wr_data && !is_full(txf_cnt, fctl_r[uaf_pkg::FC_EN])),
		.din   (WDATA),
		.pop   (tx_go),
		.dout  (txf_dout),
		.count (txf_cnt)
	);

	// pause only between characters, never mid-frame
	assign tx_go  = (tx_st_r == uaf_pkg::TX_IDLE) && (txf_cnt != 5'h00)
		&& !(efeat_r[uaf_pkg::EF_ACTS] && cts_n_r);
	assign tx_end = tick && (tx_cnt_r == os_n - 5'h01);
	assign thre   = (txf_cnt == 5'h00);
	assign temt   = thre && (tx_st_r == uaf_pkg::TX_IDLE);

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			tx_cnt_r <= 5'h00;
		end else if (tx_st_r == uaf_pkg::TX_IDLE) begin
			tx_cnt_r <= 5'h00;
		end else if (tick) begin
			tx_cnt_r <= tx_end ? 5'h00 : tx_cnt_r + 5'h01;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			tx_st_r  <= uaf_pkg::TX_IDLE;
			tx_bit_r <= 3'h0;
			tx_sh_r  <= 8'h00;
			tx_par_r <= 1'b0;
			tx_stp_r <= 1'b0;
			tx_o_r   <= 1'b1;
		end else begin
			unique case (tx_st_r)
				uaf_pkg::TX_IDLE: if (tx_go) begin
					tx_st_r  <= uaf_pkg::TX_START;
					tx_sh_r  <= txf_dout;
					tx_par_r <= par_of(txf_dout, lctl_r);
					tx_o_r   <= 1'b0;
				end
				uaf_pkg::TX_START: if (tx_end) begin
					tx_st_r  <= uaf_pkg::TX_DATA;
					tx_bit_r <= 3'h0;
					tx_o_r   <= tx_sh_r[0];
				end
				uaf_pkg::TX_DATA: if (tx_end) begin
					if (tx_bit_r == last_bit && lctl_r[uaf_pkg::LC_PEN]) begin
						tx_st_r <= uaf_pkg::TX_PAR;
						tx_o_r  <= tx_par_r;
					end else if (tx_bit_r == last_bit) begin
						tx_st_r  <= uaf_pkg::TX_STOP;
						tx_stp_r <= lctl_r[uaf_pkg::LC_STOP];
						tx_o_r   <= 1'b1;
					end else begin
						tx_sh_r  <= tx_sh_r >> 1;
						tx_o_r   <= tx_sh_r[1];
						tx_bit_r <= tx_bit_r + 3'h1;
					end
				end
				uaf_pkg::TX_PAR: if (tx_end) begin
					tx_st_r  <= uaf_pkg::TX_STOP;
					tx_stp_r <= lctl_r[uaf_pkg::LC_STOP];
					tx_o_r   <= 1'b1;
				end
				uaf_pkg::TX_STOP: if (tx_end) begin
					if (tx_stp_r) begin
						tx_stp_r <= 1'b0;
					end else begin
						tx_st_r <= uaf_pkg::TX_IDLE;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// receiver
	// ----------------------------------------------------------------
	assign rx_end  = tick && (rx_cnt_r == os_n - 5'h01);
	assign rx_mid  = tick && (rx_cnt_r == (os_n >> 1) - 5'h01);
	assign rx_data = rx_sh_r >> (2'h3 - lctl_r[1:0]);
	assign rx_brk  = (rx_data == 8'h00) && !rx_r && !rx_pb_r;
	// full fifo drops the character and flags overrun instead
	assign rx_push = (rx_st_r == uaf_pkg::RX_STOP) && rx_end
		&& !is_full(rxf_cnt, fctl_r[uaf_pkg::FC_EN]);

	uaf_fifo #(.W(uaf_pkg::RX_W)) u_rxf (
		.clk   (SYS_CLK),
		.rstn  (RSTN),
		.clr   (WR && ADDR == uaf_pkg::A_ISRC && WDATA[uaf_pkg::FC_RXCLR]),
		.push  (rx_push),
		.din   ({rx_brk, !rx_r, rx_pe_r, rx_data}),
		.pop   (rd_data),
		.dout  (rxf_dout),
		.count (rxf_cnt)
	);

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			rx_cnt_r <= 5'h00;
		end else if (rx_st_r == uaf_pkg::RX_IDLE) begin
			rx_cnt_r <= 5'h00;
		end else if (tick) begin
			rx_cnt_r <= (rx_end || (rx_st_r == uaf_pkg::RX_START && rx_mid)) ? 5'h00
				: rx_cnt_r + 5'h01;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			rx_st_r   <= uaf_pkg::RX_IDLE;
			rx_prev_r <= 1'b1;
			rx_bit_r  <= 3'h0;
			rx_sh_r   <= 8'h00;
			rx_pe_r   <= 1'b0;
			rx_pb_r   <= 1'b0;
		end else begin
			rx_prev_r <= rx_r;
			unique case (rx_st_r)
				uaf_pkg::RX_IDLE: if (rx_prev_r && !rx_r) begin
					rx_st_r <= uaf_pkg::RX_START;
					rx_pe_r <= 1'b0;
					rx_pb_r <= 1'b0;
				end
				uaf_pkg::RX_START: if (rx_mid) begin
					rx_st_r  <= rx_r ? uaf_pkg::RX_IDLE : uaf_pkg::RX_DATA;
					rx_bit_r <= 3'h0;
				end
				uaf_pkg::RX_DATA: if (rx_end) begin
					rx_sh_r  <= {rx_r, rx_sh_r[7:1]};
					rx_bit_r <= rx_bit_r + 3'h1;
					if (rx_bit_r == last_bit) begin
						rx_st_r <= lctl_r[uaf_pkg::LC_PEN] ? uaf_pkg::RX_PAR
							: uaf_pkg::RX_STOP;
					end
				end
				uaf_pkg::RX_PAR: if (rx_end) begin
					rx_pb_r <= rx_r;
					rx_pe_r <= rx_r ^ par_of(rx_data, lctl_r);
					rx_st_r <= uaf_pkg::RX_STOP;
				end
				uaf_pkg::RX_STOP: if (rx_end) begin
					rx_st_r <= uaf_pkg::RX_IDLE;
				end
			endcase
		end
	end

	// overrun: set wins over the status read that clears it
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			oe_r <= 1'b0;
		end else begin
			oe_r <= ((rx_st_r == uaf_pkg::RX_STOP) && rx_end && !rx_push)
				|| (oe_r && !(RD && ADDR == uaf_pkg::A_LSTAT));
		end
	end

	// ----------------------------------------------------------------
	// receive time-out
	// ----------------------------------------------------------------
	assign tmo_lim = 8'({4'h0, 4'h7 + {2'h0, lctl_r[1:0]} + {3'h0, lctl_r[uaf_pkg::LC_PEN]}
		+ {3'h0, lctl_r[uaf_pkg::LC_STOP]}} * uaf_pkg::TMO_CHARS) + uaf_pkg::TMO_BITS;

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			bt_cnt_r  <= 5'h00;
			tmo_cnt_r <= 8'h00;
			tmo_r     <= 1'b0;
		end else begin
			if (tick) begin
				bt_cnt_r <= (bt_cnt_r >= os_n - 5'h01) ? 5'h00 : bt_cnt_r + 5'h01;
			end
			if (rx_push || rd_data || rxf_empty) begin
				tmo_cnt_r <= 8'h00;
			end else if (tick && bt_cnt_r == os_n - 5'h01 && tmo_cnt_r != tmo_lim) begin
				tmo_cnt_r <= tmo_cnt_r + 8'h01;
			end
			tmo_r <= (tmo_r && !rd_data && !rxf_empty)
				|| (fctl_r[uaf_pkg::FC_EN] && !rxf_empty && tmo_cnt_r == tmo_lim);
		end
	end

	// ----------------------------------------------------------------
	// request-to-send hysteresis and flow events
	// ----------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			rts_off_r <= 1'b0;
			rts_n_r   <= 1'b1;
			rts_d_r   <= 1'b1;
			cts_d_r   <= 1'b1;
		end else begin
			if (rxf_cnt >= uaf_pkg::RTS_HI[tsel]) begin
				rts_off_r <= 1'b1;
			end else if (rxf_cnt <= uaf_pkg::RTS_LO[tsel]) begin
				rts_off_r <= 1'b0;
			end
			// automatic control only runs once software has asserted the pin
			if (efeat_r[uaf_pkg::EF_ARTS] && mctl_r[uaf_pkg::MC_RTS]) begin
				rts_n_r <= rts_off_r;
			end else begin
				rts_n_r <= !mctl_r[uaf_pkg::MC_RTS];
			end
			rts_d_r <= rts_n_r;
			cts_d_r <= cts_n_r;
		end
	end

	// ----------------------------------------------------------------
	// interrupt source
	// ----------------------------------------------------------------
	assign rxd_cond = fctl_r[uaf_pkg::FC_EN] ? (rxf_cnt >= uaf_pkg::TRIG_LVL[tsel])
		: !rxf_empty;

	always_comb begin
		if (ien_r[uaf_pkg::IE_RXD] && tmo_r) begin
			isrc = uaf_pkg::IS_TMO;
		end else if (ien_r[uaf_pkg::IE_RXD] && rxd_cond) begin
			isrc = uaf_pkg::IS_RXD;
		end else if (thri_r) begin
			isrc = uaf_pkg::IS_THRE;
		end else if (flow_r) begin
			isrc = uaf_pkg::IS_FLOW;
		end else begin
			isrc = uaf_pkg::IS_NONE;
		end
	end

	// pending flags: a new event in the clearing cycle is kept
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			thre_d_r <= 1'b0;
			thri_r   <= 1'b0;
			flow_r   <= 1'b0;
			int_r    <= 1'b0;
		end else begin
			thre_d_r <= thre && ien_r[uaf_pkg::IE_THRE];
			thri_r   <= (thre && ien_r[uaf_pkg::IE_THRE] && !thre_d_r)
				|| (thri_r && ien_r[uaf_pkg::IE_THRE] && !wr_data
				&& !(rd_isrc && isrc == uaf_pkg::IS_THRE));
			flow_r   <= (ien_r[uaf_pkg::IE_RTS] && rts_n_r && !rts_d_r)
				|| (ien_r[uaf_pkg::IE_CTS] && cts_n_r && !cts_d_r)
				|| (flow_r && !(rd_isrc && isrc == uaf_pkg::IS_FLOW));
			int_r    <= (isrc != uaf_pkg::IS_NONE);
		end
	end

	assign RDATA = rdata_r;
	assign TX    = tx_o_r;
	assign RTS_N = rts_n_r;
	assign INT   = int_r;

endmodule

// ### include/uaf_pkg.sv
/*
 * uaf_pkg: register map, field positions, reset values and serial timing constants
 * for the serial port datapath with automatic request/clear-to-send flow control.
 * assumes: every user writes names out as uaf_pkg::name, nothing is imported.
 */
package uaf_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [3:0] A_DATA  = 4'h0;
	localparam logic [3:0] A_IEN   = 4'h1;
	localparam logic [3:0] A_ISRC  = 4'h2;
	localparam logic [3:0] A_LCTL  = 4'h3;
	localparam logic [3:0] A_MCTL  = 4'h4;
	localparam logic [3:0] A_LSTAT = 4'h5;
	localparam logic [3:0] A_EFEAT = 4'h6;
	localparam logic [3:0] A_FDIV  = 4'h7;
	localparam logic [3:0] A_BDIV  = 4'h8;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int IE_RXD   = 0;
	localparam int IE_THRE  = 1;
	localparam int IE_RTS   = 6;
	localparam int IE_CTS   = 7;
	localparam int FC_EN    = 0;
	localparam int FC_RXCLR = 1;
	localparam int FC_TXCLR = 2;
	localparam int FC_TRIG  = 6;
	localparam int MC_RTS   = 1;
	localparam int EF_ENH   = 4;
	localparam int EF_ARTS  = 6;
	localparam int EF_ACTS  = 7;
	localparam int LC_STOP  = 2;
	localparam int LC_PEN   = 3;
	localparam int LC_EVEN  = 4;
	localparam int FD_OS    = 4;

	// ----------------------------------------------------------------
	// interrupt source codes, reset values
	// ----------------------------------------------------------------
	localparam logic [5:0] IS_NONE = 6'h01;
	localparam logic [5:0] IS_THRE = 6'h02;
	localparam logic [5:0] IS_RXD  = 6'h04;
	localparam logic [5:0] IS_TMO  = 6'h0C;
	localparam logic [5:0] IS_FLOW = 6'h20;
	localparam logic [7:0] LCTL_RST = 8'h03;
	localparam logic [7:0] ZERO_RST = 8'h00;

	// ----------------------------------------------------------------
	// oversampling and fifo levels
	// ----------------------------------------------------------------
	localparam logic [1:0] OS_16 = 2'h0;
	localparam logic [1:0] OS_8  = 2'h1;
	localparam logic [1:0] OS_4  = 2'h2;
	localparam logic [4:0] OS_LEN [4] = '{5'h10, 5'h08, 5'h04, 5'h10};
	localparam int FIFO_AW = 4;
	localparam logic [4:0] FIFO_DEPTH = 5'h10;
	localparam int RX_W = 11;
	localparam logic [4:0] TRIG_LVL [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
	localparam logic [4:0] RTS_HI [4]   = '{5'h04, 5'h08, 5'h0E, 5'h0E};
	localparam logic [4:0] RTS_LO [4]   = '{5'h00, 5'h01, 5'h08, 5'h0E};
	localparam logic [7:0] TMO_CHARS = 8'h04;
	localparam logic [7:0] TMO_BITS  = 8'h0C;

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;

endpackage

// ### hdl/uaf_fifo.sv
/*
 * uaf_fifo: sixteen-entry synchronous fifo, head word visible without a read cycle.
 * assumes: one clock; push while full and pop while empty are ignored.
 */
`timescale 1ns/10ps
module uaf_fifo #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic         clr,
	input  wire logic         push,
	input  wire logic [W-1:0] din,
	input  wire logic         pop,
	output logic      [W-1:0] dout,
	output logic      [4:0]   count
);

	logic [W-1:0] mem [uaf_pkg::FIFO_DEPTH];
	logic [uaf_pkg::FIFO_AW-1:0] wp_r;
	logic [uaf_pkg::FIFO_AW-1:0] rp_r;
	logic [4:0] cnt_r;
	logic       do_push;
	logic       do_pop;

	assign do_push = push && (cnt_r != uaf_pkg::FIFO_DEPTH);
	assign do_pop  = pop && (cnt_r != 5'h00);
	assign dout    = mem[rp_r];
	assign count   = cnt_r;

	always_ff @(posedge clk) begin
		if (do_push) begin
			mem[wp_r] <= din;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wp_r  <= 4'h0;
			rp_r  <= 4'h0;
			cnt_r <= 5'h00;
		end else if (clr) begin
			wp_r  <= 4'h0;
			rp_r  <= 4'h0;
			cnt_r <= 5'h00;
		end else begin
			if (do_push) begin
				wp_r <= wp_r + 4'h1;
			end
			if (do_pop) begin
				rp_r <= rp_r + 4'h1;
			end
			cnt_r <= cnt_r + {4'h0, do_push} - {4'h0, do_pop};
		end
	end

endmodule

// ### dv/uaf_top_monitor.sv
/*
 * uaf_top_monitor: port-level assertions for the serial port datapath.
 * assumes: bound to uaf_top, one clock, sees only the top ports.
 */
`timescale 1ns/10ps
module uaf_top_monitor (
	input wire logic       SYS_CLK,
	input wire logic       RSTN,
	input wire logic [3:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic       WR,
	input wire logic       RD,
	input wire logic [7:0] RDATA,
	input wire logic       RX,
	input wire logic       TX,
	input wire logic       CTS_N,
	input wire logic       RTS_N,
	input wire logic       INT
);
	logic [7:0] ef_r;
	logic [7:0] mc_r;
	logic       fen_r;
	logic [7:0] cts_cnt_r;
	logic [7:0] idle_cnt_r;
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RSTN);
	// ------------------------------------------------
	// shadow of the control registers
	// ------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			ef_r <= 8'h00;
			mc_r <= 8'h00;
			fen_r <= 1'b0;
		end else if (WR) begin
			if (ADDR == uaf_pkg::A_EFEAT) ef_r <= WDATA;
			if (ADDR == uaf_pkg::A_MCTL) mc_r <= WDATA;
			if (ADDR == uaf_pkg::A_ISRC) fen_r <= WDATA[uaf_pkg::FC_EN];
		end
	end
	// long high runs on TX only happen between frames at divisor 0
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			cts_cnt_r <= 8'h00;
			idle_cnt_r <= 8'h00;
		end else begin
			cts_cnt_r <= !CTS_N ? 8'h00 : (cts_cnt_r == 8'hFF) ? cts_cnt_r : cts_cnt_r + 8'h01;
			idle_cnt_r <= !TX ? 8'h00 : (idle_cnt_r == 8'hFF) ? idle_cnt_r : idle_cnt_r + 8'h01;
		end
	end
	chk_bit_min: assert property ($changed(TX) |=> $stable(TX) [*2])
		else $error("serial bit shorter than three clocks");
	chk_rdata_idle: assert property (!RD |=> RDATA == 8'h00)
		else $error("read data not zero outside read answer");
	chk_temt_thre: assert property (RD && ADDR == uaf_pkg::A_LSTAT |=> !RDATA[6] || RDATA[5])
		else $error("transmitter empty while holding not empty");
	chk_temt_busy: assert property (RD && ADDR == uaf_pkg::A_LSTAT && !TX |=> !RDATA[6])
		else $error("transmitter empty while shifting");
	chk_status_top: assert property (RD && ADDR == uaf_pkg::A_LSTAT |=> !RDATA[7])
		else $error("line status top bit set");
	chk_src_fifo: assert property (RD && ADDR == uaf_pkg::A_ISRC |=> RDATA[7:6] == {2{fen_r}})
		else $error("interrupt source fifo bits wrong");
	chk_unmapped_zero: assert property (RD && ADDR > uaf_pkg::A_BDIV |=> RDATA == 8'h00)
		else $error("unmapped index read not zero");
	chk_rts_manual: assert property (!(ef_r[uaf_pkg::EF_ARTS] && mc_r[uaf_pkg::MC_RTS])
		&& $stable(mc_r) && $stable(ef_r) |-> RTS_N == !mc_r[uaf_pkg::MC_RTS])
		else $error("request-to-send not following modem control");
	chk_cts_pause: assert property (ef_r[uaf_pkg::EF_ACTS] && cts_cnt_r > 8'h08
		&& idle_cnt_r > 8'hC8 |=> TX)
		else $error("frame started while clear-to-send high");
endmodule
bind uaf_top uaf_top_monitor u_mon (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .ADDR(ADDR),
	.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .RX(RX), .TX(TX), .CTS_N(CTS_N),
	.RTS_N(RTS_N), .INT(INT));

// ### dv/uaf_remote.sv
/*
 * uaf_remote: remote serial device, sends frames on rx and decodes tx.
 * assumes: bench sets bt to the bit length in clocks and drives hold.
 */
`timescale 1ns/10ps
module uaf_remote (
	input  wire logic clk,
	input  wire logic tx,
	input  wire logic rts_n,
	output logic      rx,
	output logic      cts_n
);
	int         bt = 16;
	int         k;
	logic       hold = 1'b0;
	logic [8:0] v;
	logic [8:0] got[$];
	initial rx = 1'b1;
	assign cts_n = hold;
	task automatic send(input logic [7:0] b);
		int i;
		// remote holds off while request-to-send is high
		while (rts_n) @(posedge clk);
		for (i = 0; i < 10; i++) begin
			rx <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
			repeat (bt) @(posedge clk);
		end
	endtask
	// nine samples: eight data bits then parity or stop
	always begin
		@(negedge tx);
		repeat (bt / 2) @(posedge clk);
		if (!tx) begin
			for (k = 0; k < 9; k++) begin
				repeat (bt) @(posedge clk);
				v[k] = tx;
			end
			got.push_back(v);
		end
	end
endmodule

// ### dv/uart_txrx_auto_flow_control_tb.sv
/*
 * uart_txrx_auto_flow_control_tb: self-checking bench for uaf_top.
 * assumes: uaf_remote on the serial side, divisor left at 0.
 */
`timescale 1ns/10ps
module uart_txrx_auto_flow_control_tb;
	logic       SYS_CLK, RSTN, WR, RD, TX, RTS_N, INT, RX, CTS_N, pe;
	logic [3:0] ADDR;
	logic [7:0] WDATA, RDATA, q, b;
	logic [7:0] txq[$], rxq[$];
	int         n_mismatch, n_compared, cyc, seed, i, m;
	uaf_top DUT (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
		.RD(RD), .RDATA(RDATA), .RX(RX), .TX(TX), .CTS_N(CTS_N), .RTS_N(RTS_N), .INT(INT));
	uaf_remote REM (.clk(SYS_CLK), .tx(TX), .rts_n(RTS_N), .rx(RX), .cts_n(CTS_N));
	initial begin
		SYS_CLK = 1'b0;
		forever #5 SYS_CLK = ~SYS_CLK;
	end
	always @(posedge SYS_CLK) begin
		cyc++;
		if (cyc == 60000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [8:0] g, input logic [8:0] e);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge SYS_CLK);
		WR <= 1'b0;
		@(posedge SYS_CLK);
	endtask
	task automatic rdc(input logic [3:0] a, input logic [7:0] e);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge SYS_CLK);
		RD <= 1'b0;
		#1 q = RDATA;
		chk(q, e);
		@(posedge SYS_CLK);
	endtask
	// expected frame: eight data bits, then even parity or the stop bit
	task automatic drain();
		int w;
		while (txq.size() > 0) begin
			for (w = 0; w < 4000 && REM.got.size() == 0; w++) @(posedge SYS_CLK);
			b = txq.pop_front();
			chk(REM.got.pop_front(), {pe ? ^b : 1'b1, b});
		end
	endtask
	task report_and_stop();
		$display("mismatches %0d compared %0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		seed = 32'h227C;
		{RSTN, WR, RD, ADDR, WDATA, pe} = '0;
		repeat (12) @(posedge SYS_CLK);
		RSTN <= 1'b1;
		@(posedge SYS_CLK);
		rdc(uaf_pkg::A_LSTAT, 8'h60);
		rdc(uaf_pkg::A_LCTL, uaf_pkg::LCTL_RST);
		rdc(4'hC, 8'h00);
		for (m = 0; m < 3; m++) begin
			wr(uaf_pkg::A_FDIV, 8'(m * 16));
			REM.bt = uaf_pkg::OS_LEN[m];
			pe = (m == 2);
			wr(uaf_pkg::A_LCTL, pe ? 8'h1B : 8'h03);
			b = $random(seed);
			txq.push_back(b);
			wr(uaf_pkg::A_DATA, b);
			drain();
		end
		wr(uaf_pkg::A_FDIV, 8'h00);
		REM.bt = 16;
		pe = 1'b0;
		wr(uaf_pkg::A_LCTL, 8'h03);
		wr(uaf_pkg::A_ISRC, 8'h01);
		for (i = 0; i < 3; i++) begin
			b = $random(seed);
			txq.push_back(b);
			wr(uaf_pkg::A_DATA, b);
		end
		rdc(uaf_pkg::A_LSTAT, 8'h00);
		drain();
		repeat (24) @(posedge SYS_CLK);
		rdc(uaf_pkg::A_LSTAT, 8'h60);
		wr(uaf_pkg::A_IEN, 8'h02);
		rdc(uaf_pkg::A_ISRC, 8'hC2);
		rdc(uaf_pkg::A_ISRC, 8'hC1);
		wr(uaf_pkg::A_EFEAT, 8'h50);
		wr(uaf_pkg::A_IEN, 8'hC0);
		wr(uaf_pkg::A_MCTL, 8'h02);
		// pin updates on this edge; look once it has settled
		#1 chk(RTS_N, 1'b0);
		for (i = 0; i < 4; i++) begin
			b = $random(seed);
			rxq.push_back(b);
			REM.send(b);
		end
		repeat (8) @(posedge SYS_CLK);
		chk(RTS_N, 1'b1);
		chk(INT, 1'b1);
		rdc(uaf_pkg::A_ISRC, 8'hC0 | 8'(uaf_pkg::IS_FLOW));
		wr(uaf_pkg::A_IEN, 8'hC1);
		rdc(uaf_pkg::A_ISRC, 8'hC4);
		// idle longer than four characters plus twelve bits at 16X
		repeat (900) @(posedge SYS_CLK);
		rdc(uaf_pkg::A_ISRC, 8'hCC);
		for (i = 0; i < 4; i++) rdc(uaf_pkg::A_DATA, rxq.pop_front());
		repeat (4) @(posedge SYS_CLK);
		chk(RTS_N, 1'b0);
		wr(uaf_pkg::A_EFEAT, 8'h80);
		REM.hold <= 1'b1;
		repeat (8) @(posedge SYS_CLK);
		chk(INT, 1'b1);
		rdc(uaf_pkg::A_ISRC, 8'hC0 | 8'(uaf_pkg::IS_FLOW));
		b = $random(seed);
		txq.push_back(b);
		wr(uaf_pkg::A_DATA, b);
		repeat (400) @(posedge SYS_CLK);
		chk(REM.got.size() == 0, 1'b1);
		REM.hold <= 1'b0;
		drain();
		report_and_stop();
	end
endmodule
